/* src/pll_ctl_consts.svh */
`ifndef PLL_CTL_CONSTS_SVH
`define PLL_CTL_CONSTS_SVH

// register map
`define CTL_ADDR        12'h000
`define ADDR_LSB        2
`define ADDR_MSB        11
`define CTL_RESET       32'h0000_0000

// control field positions
`define MULT_LSB        0
`define MULT_MSB        5
`define DIV_LSB         6
`define DIV_MSB         7
`define HALVE_BIT       8
`define POST_DIV_EN_BIT 9
`define CLKOUT_SEL_BIT  12
`define BYPASS_BIT      15
`define GATE_LSB        16
`define GATE_MSB        19
`define SPI_STOP_BIT    30
`define CTL_WMASK       32'h400F_93FF

// peripheral clock index
`define GATE_TIMER      0
`define GATE_SPI        1

// ratio strap codes and their multipliers
`define STRAP_3_1       2'h0
`define STRAP_16_1      2'h1
`define STRAP_8_1       2'h2
`define MULT_3_1        6'h06
`define MULT_16_1       6'h20
`define MULT_8_1        6'h10

// field decoding
`define MULT_ZERO       6'h00
`define MULT_64         7'h40
`define DIV_BY_2        5'h02
`define DIV_BY_4        5'h04
`define DIV_BY_8        5'h08
`define DIV_BY_16       5'h10

// lock and boot wait, in input clock cycles (4096)
`define WAIT_LAST       12'hFFF
`define WAIT_ONE        12'h001
`define WAIT_ZERO       12'h000

// ahb
`define HTRANS_NONSEQ   2'h2
`define HSIZE_WORD      3'h2

`endif

/* src/pll_ctl_pkg.sv */
package pll_ctl_pkg;
    typedef enum logic [0:0] {
        lock_idle = 1'b0,
        lock_wait = 1'b1
    } lock_state_e;
endpackage

/* src/pll_core_clock_power_control.sv */
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "pll_ctl_consts.svh"

// How it works
// - peripheral clocks off, set on init, software clears
// - shared pin: reset out, clock out when bit12
// - bit15 bypasses pll, core runs input clock
// - ratio pins load pll defaults at reset
// - divider 2/4/8/16, multiplier zero means 64
// - bit8 halves input clock before pll
// - bit30 stops spi clock, flags unusable
// - outside bypass and lock wait core is input times mult/div
// - chip reset held 4096 cycles by counter
// - divider code 11 is 16, multiplier 63 is 63
module pll_core_clock_power_control (
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // straps and peripheral init strobes
    input  wire logic [1:0]  ratio_select_pins,
    input  wire logic [3:0]  periph_init,
    // clock control results
    output logic [3:0]       periph_clock_enable,
    output logic             shared_pin_out,
    output logic             chip_reset_n,
    output logic             core_from_pll,
    output logic             input_halved,
    output logic [6:0]       core_multiplier,
    output logic [4:0]       core_divider
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0]              power_clock_control;
    logic [31:0]              next_ctl;
    logic                     strap_done;
    logic                     next_strap_done;
    logic                     wr_pend;
    logic                     next_wr_pend;
    logic [11:0]              boot_count;
    logic [11:0]              next_boot_count;
    logic                     next_chip_reset_n;
    pll_ctl_pkg::lock_state_e lock_state;
    pll_ctl_pkg::lock_state_e next_lock_state;
    logic [11:0]              lock_count;
    logic [11:0]              next_lock_count;
    logic                     clkout_phase;
    logic [31:0]              next_hrdata;
    logic [3:0]               next_gate;
    logic                     next_pin;
    logic                     next_from_pll;
    logic                     next_halved;
    logic [6:0]               next_mult;
    logic [4:0]               next_div;
    logic                     addr_ok;
    logic                     cfg_change;
    logic [31:0]              wr_value;

    function automatic logic [6:0] mult_decode(input logic [5:0] f);
        mult_decode = (f == `MULT_ZERO) ? `MULT_64 : {1'b0, f};
    endfunction

    function automatic logic [4:0] div_decode(input logic [1:0] f);
        unique case (f)
            2'h0: div_decode = `DIV_BY_2;
            2'h1: div_decode = `DIV_BY_4;
            2'h2: div_decode = `DIV_BY_8;
            2'h3: div_decode = `DIV_BY_16;
        endcase
    endfunction

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb begin
        addr_ok         = hsel && hready && htrans == `HTRANS_NONSEQ
                          && hsize == `HSIZE_WORD && haddr == `CTL_ADDR;
        next_wr_pend    = addr_ok && hwrite;
        // unmapped or non-word reads answer zero
        next_hrdata     = (addr_ok && !hwrite) ? power_clock_control : 32'h0000_0000;
        wr_value        = hwdata & `CTL_WMASK;
        next_ctl        = power_clock_control;
        next_strap_done = 1'b1;
        if (!strap_done) begin
            next_ctl = `CTL_RESET;
            unique case (ratio_select_pins)
                `STRAP_16_1: next_ctl[`MULT_MSB:`MULT_LSB] = `MULT_16_1;
                `STRAP_8_1:  next_ctl[`MULT_MSB:`MULT_LSB] = `MULT_8_1;
                // reserved code falls back to the slowest ratio
                default:     next_ctl[`MULT_MSB:`MULT_LSB] = `MULT_3_1;
            endcase
        end else if (wr_pend) begin
            next_ctl = wr_value;
        end
        // init strobe wins over a software clear in the same cycle
        next_ctl[`GATE_MSB:`GATE_LSB] = next_ctl[`GATE_MSB:`GATE_LSB]
                                        | (strap_done ? periph_init : 4'h0);
        next_gate = next_ctl[`GATE_MSB:`GATE_LSB];
        if (next_ctl[`SPI_STOP_BIT]) begin
            next_gate[`GATE_SPI] = 1'b0;
        end

        // boot hold after external reset release
        next_boot_count   = boot_count;
        next_chip_reset_n = chip_reset_n;
        if (!chip_reset_n) begin
            next_boot_count = boot_count + `WAIT_ONE;
            if (boot_count == `WAIT_LAST) begin
                next_chip_reset_n = 1'b1;
            end
        end

        // ratio change: pll relocks before the new ratio takes over
        cfg_change = strap_done && (
                     mult_decode(power_clock_control[`MULT_MSB:`MULT_LSB]) != core_multiplier
                     || div_decode(power_clock_control[`DIV_MSB:`DIV_LSB]) != core_divider
                     || power_clock_control[`HALVE_BIT] != input_halved);
        next_lock_state = lock_state;
        next_lock_count = lock_count;
        next_mult       = core_multiplier;
        next_div        = core_divider;
        next_halved     = input_halved;
        unique case (lock_state)
            pll_ctl_pkg::lock_idle: begin
                if (cfg_change) begin
                    next_lock_state = pll_ctl_pkg::lock_wait;
                    next_lock_count = `WAIT_ZERO;
                end
            end
            pll_ctl_pkg::lock_wait: begin
                next_lock_count = lock_count + `WAIT_ONE;
                if (wr_pend) begin
                    // a rewrite during lock restarts the wait
                    next_lock_count = `WAIT_ZERO;
                end else if (lock_count == `WAIT_LAST) begin
                    next_lock_state = pll_ctl_pkg::lock_idle;
                    next_mult   = mult_decode(power_clock_control[`MULT_MSB:`MULT_LSB]);
                    next_div    = div_decode(power_clock_control[`DIV_MSB:`DIV_LSB]);
                    next_halved = power_clock_control[`HALVE_BIT];
                end
            end
        endcase
        // registered select: source only swaps between whole cycles,
        // and the input clock carries the core while the pll locks
        next_from_pll = !next_ctl[`BYPASS_BIT]
                        && next_lock_state == pll_ctl_pkg::lock_idle;
        next_pin = power_clock_control[`CLKOUT_SEL_BIT] ? clkout_phase
                                                        : chip_reset_n;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_clock_control <= `CTL_RESET;
            strap_done          <= 1'b0;
            wr_pend             <= 1'b0;
            boot_count          <= `WAIT_ZERO;
            chip_reset_n        <= 1'b0;
            lock_state          <= pll_ctl_pkg::lock_idle;
            lock_count          <= `WAIT_ZERO;
            clkout_phase        <= 1'b0;
            hreadyout           <= 1'b1;
            hresp               <= 1'b0;
            hrdata              <= 32'h0000_0000;
            periph_clock_enable <= 4'h0;
            shared_pin_out      <= 1'b0;
            core_from_pll       <= 1'b0;
            input_halved        <= 1'b0;
            core_multiplier     <= {1'b0, `MULT_3_1};
            core_divider        <= `DIV_BY_2;
        end else if (ce) begin
            power_clock_control <= next_ctl;
            strap_done          <= next_strap_done;
            wr_pend             <= next_wr_pend;
            boot_count          <= next_boot_count;
            chip_reset_n        <= next_chip_reset_n;
            lock_state          <= next_lock_state;
            lock_count          <= next_lock_count;
            clkout_phase        <= !clkout_phase;
            hreadyout           <= 1'b1;
            hresp               <= 1'b0;
            hrdata              <= next_hrdata;
            periph_clock_enable <= next_gate;
            shared_pin_out      <= next_pin;
            core_from_pll       <= next_from_pll;
            input_halved        <= next_halved;
            core_multiplier     <= next_mult;
            core_divider        <= next_div;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_gates_off_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        !strap_done |-> periph_clock_enable == 4'h0)
        else $error("peripheral clock on before init");
    chk_gate_sticky_on: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && strap_done && periph_init[`GATE_TIMER] |=> periph_clock_enable[`GATE_TIMER])
        else $error("timer clock not enabled by init");
    chk_pin_reset_out: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !power_clock_control[`CLKOUT_SEL_BIT] |=> shared_pin_out == $past(chip_reset_n))
        else $error("shared pin not reset out");
    chk_bypass_source: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && next_ctl[`BYPASS_BIT] |=> !core_from_pll)
        else $error("pll not bypassed");
    chk_strap_16: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !strap_done && ratio_select_pins == `STRAP_16_1
        |=> power_clock_control[`MULT_MSB:`MULT_LSB] == `MULT_16_1)
        else $error("strap default wrong");
    chk_apply_decode: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && lock_state == pll_ctl_pkg::lock_wait && !wr_pend && lock_count == `WAIT_LAST
        && power_clock_control[`MULT_MSB:`MULT_LSB] == `MULT_ZERO
        |=> core_multiplier == `MULT_64 && core_from_pll == !power_clock_control[`BYPASS_BIT])
        else $error("multiplier zero not 64");
    chk_spi_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        power_clock_control[`SPI_STOP_BIT] |-> !periph_clock_enable[`GATE_SPI])
        else $error("spi clock runs while stopped");
    chk_boot_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !chip_reset_n && boot_count != `WAIT_LAST |=> !chip_reset_n)
        else $error("chip reset released early");
    chk_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        lock_state == pll_ctl_pkg::lock_wait |-> !core_from_pll ##1 $stable(core_multiplier)
        || $past(lock_count) == `WAIT_LAST)
        else $error("ratio changed during lock");
    chk_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && wr_pend && strap_done ##1 ce && hsel && hready && htrans == `HTRANS_NONSEQ
        && !hwrite && hsize == `HSIZE_WORD && haddr == `CTL_ADDR && periph_init == 4'h0
        |=> hrdata == ($past(hwdata, 2) & `CTL_WMASK))
        else $error("read back mismatch");

endmodule

/* dv/tb.sv */
`timescale 1ns/1ns
`include "pll_ctl_consts.svh"

module tb;
    // ---------------------------------------------
    // signals
    // ---------------------------------------------
    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [1:0]  ratio_select_pins;
    logic [3:0]  periph_init;
    logic [3:0]  periph_clock_enable;
    logic        shared_pin_out;
    logic        chip_reset_n;
    logic        core_from_pll;
    logic        input_halved;
    logic [6:0]  core_multiplier;
    logic [4:0]  core_divider;
    int          mismatches;
    int          n_compared;
    logic [31:0] rd;
    logic [31:0] ctl;
    logic [6:0]  prev_mult;
    logic        pin_was;
    logic [1:0]  straps     [3];
    logic [6:0]  strap_mult [3];
    logic [5:0]  mult_code  [3];
    logic [6:0]  mult_val   [3];
    logic [1:0]  div_code   [3];
    logic [4:0]  div_val    [3];

    // ---------------------------------------------
    // device and clock
    // ---------------------------------------------
    pll_core_clock_power_control dut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ratio_select_pins(ratio_select_pins), .periph_init(periph_init),
        .periph_clock_enable(periph_clock_enable), .shared_pin_out(shared_pin_out),
        .chip_reset_n(chip_reset_n), .core_from_pll(core_from_pll),
        .input_halved(input_halved), .core_multiplier(core_multiplier),
        .core_divider(core_divider)
    );

    always #2 hclk = ~hclk;

    // ---------------------------------------------
    // tasks
    // ---------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // single word transfer, started just after the caller's edge so that
    // calls run back to back; rd holds read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= `HTRANS_NONSEQ;
        hsize  <= `HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic do_reset(input logic [1:0] s);
        hresetn           <= 1'b0;
        ratio_select_pins <= s;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ---------------------------------------------
    // tests
    // ---------------------------------------------
    initial begin
        repeat (40000) @(posedge hclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 12'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h0; hwdata = 32'h0; ratio_select_pins = 2'h0;
        periph_init = 4'h0; mismatches = 0; n_compared = 0; ce = 1'b1;
        straps     = '{`STRAP_3_1, `STRAP_8_1, `STRAP_16_1};
        strap_mult = '{7'h06, 7'h10, 7'h20};
        mult_code  = '{6'h00, 6'h3F, 6'h08};
        mult_val   = '{7'h40, 7'h3F, 7'h08};
        div_code   = '{2'h3, 2'h1, 2'h2};
        div_val    = '{5'h10, 5'h04, 5'h08};
        for (int i = 0; i < 3; i++) begin
            do_reset(straps[i]);
            repeat (100) @(posedge hclk);
            check("chip reset early", 32'h0, 32'(chip_reset_n));
            check("gates at reset", 32'h0, 32'(periph_clock_enable));
            check("pin is reset out", 32'h0, 32'(shared_pin_out));
            bus(1'b0, `CTL_ADDR, 32'h0);
            check("strap register", 32'(strap_mult[i][5:0]), rd);
            repeat (4020) @(posedge hclk);
            check("chip reset late", 32'h1, 32'(chip_reset_n));
            check("strap mult", 32'(strap_mult[i]), 32'(core_multiplier));
            check("strap div", 32'h2, 32'(core_divider));
            check("pll in use", 32'h1, 32'(core_from_pll));
            $display("test strap %0d done", i);
        end
        prev_mult = 7'h20;
        // each new ratio goes through bypass and the full lock wait
        for (int i = 0; i < 3; i++) begin
            ctl = {16'h0, 1'b1, 6'h0, 1'(i % 2), div_code[i], mult_code[i]};
            bus(1'b1, `CTL_ADDR, ctl);
            repeat (2000) @(posedge hclk);
            check("pll off in lock", 32'h0, 32'(core_from_pll));
            check("mult held", 32'(prev_mult), 32'(core_multiplier));
            repeat (2200) @(posedge hclk);
            check("mult", 32'(mult_val[i]), 32'(core_multiplier));
            check("div", 32'(div_val[i]), 32'(core_divider));
            check("halve", 32'(i % 2), 32'(input_halved));
            check("bypassed", 32'h0, 32'(core_from_pll));
            ctl = ctl & 32'hFFFF_7FFF;
            bus(1'b1, `CTL_ADDR, ctl);
            repeat (4) @(posedge hclk);
            check("pll back", 32'h1, 32'(core_from_pll));
            bus(1'b0, `CTL_ADDR, 32'h0);
            check("readback", ctl, rd);
            prev_mult = mult_val[i];
            $display("test ratio %0d done", i);
        end
        periph_init <= 4'hF;
        @(posedge hclk);
        periph_init <= 4'h0;
        repeat (2) @(posedge hclk);
        check("gates on", 32'hF, 32'(periph_clock_enable));
        bus(1'b1, `CTL_ADDR, ctl | 32'h400F_1000);
        repeat (2) @(posedge hclk);
        check("spi stopped", 32'hD, 32'(periph_clock_enable));
        pin_was = shared_pin_out;
        @(posedge hclk);
        check("clock out", 32'(!pin_was), 32'(shared_pin_out));
        // clock enable low freezes the toggling pin
        ce <= 1'b0;
        @(posedge hclk);
        pin_was = shared_pin_out;
        repeat (3) @(posedge hclk);
        check("pin frozen", 32'(pin_was), 32'(shared_pin_out));
        ce <= 1'b1;
        bus(1'b1, 12'h004, 32'h0);
        bus(1'b0, 12'h004, 32'h0);
        check("unmapped read", 32'h0, rd);
        check("response okay", 32'h0, 32'(hresp));
        bus(1'b0, `CTL_ADDR, 32'h0);
        check("unmapped write", ctl | 32'h400F_1000, rd);
        bus(1'b1, `CTL_ADDR, ctl);
        bus(1'b0, `CTL_ADDR, 32'h0);
        check("readback direct", ctl, rd);
        repeat (3) @(posedge hclk);
        check("gates off", 32'h0, 32'(periph_clock_enable));
        check("reset out back", 32'h1, 32'(shared_pin_out));
        $display("test gates done");
        tally_and_finish();
    end
endmodule
